// ### hdl/bao_byte_alu.sv
`timescale 1ns/100ps
//------------------------------------------------------------------------------
// Execution datapath for a subset of byte operations.
//------------------------------------------------------------------------------
module bao_byte_alu #(
    parameter int DW = bao_pkg::DATA_WIDTH,
    parameter int AW = bao_pkg::ADDR_WIDTH
) (
    input  wire logic            clock,
    input  wire logic            reset,
    input  wire logic            opValid,
    input  wire bao_pkg::bao_op_t opCode,
    input  wire logic [DW-1:0]   literal,
    input  wire logic [AW-1:0]   regAddr,
    input  wire logic            destIsReg,
    input  wire logic [DW-1:0]   regReadData,
    input  wire logic            wakeUp,
    output logic      [AW-1:0]   regReadAddr,
    output logic                 regWriteEn,
    output logic      [AW-1:0]   regWriteAddr,
    output logic      [DW-1:0]   regWriteData,
    output logic      [DW-1:0]   accumulator,
    output logic                 carryFlag,
    output logic                 halfCarryFlag,
    output logic                 zeroFlag,
    output logic                 expiryFlag,
    output logic                 sleepEnteredFlag,
    output logic                 watchdogClear,
    output logic                 prescalerClear,
    output logic      [7:0]      watchdogClearValue,
    output logic      [7:0]      prescalerClearValue,
    output logic                 sleepMode,
    output logic                 oscillatorRun
);

    //--------------------------------------------------------------------------
    // Operation decode.
    //--------------------------------------------------------------------------

    // One wire per operation, each qualified by the valid strobe.
    wire isPowerDown = opValid && (opCode == bao_pkg::BAO_OP_POWER_DOWN);
    wire isLitSub    = opValid && (opCode == bao_pkg::BAO_OP_LITERAL_MINUS_ACC);
    wire isRotate    = opValid && (opCode == bao_pkg::BAO_OP_ROTATE_RIGHT_VIA_CARRY);
    wire isRegSub    = opValid && (opCode == bao_pkg::BAO_OP_REG_MINUS_ACC);
    wire isSwap      = opValid && (opCode == bao_pkg::BAO_OP_NIBBLE_EXCHANGE);
    wire isLitXor    = opValid && (opCode == bao_pkg::BAO_OP_LITERAL_XOR);
    wire isRegXor    = opValid && (opCode == bao_pkg::BAO_OP_REG_XOR);

    // Operations are ignored while asleep, because the core clock would be
    // stopped in silicon and no instruction could arrive.
    wire awake = !sleepMode;

    // The register operand is read combinationally from the addressed file.
    assign regReadAddr = regAddr;

    //--------------------------------------------------------------------------
    // Arithmetic and logic results.
    //--------------------------------------------------------------------------

    // Subtrahend is always the accumulator; the minuend is literal or register.
    wire [DW-1:0] subMinuend = isLitSub ? literal : regReadData;
    logic [DW-1:0] subResult;
    logic          subNoBorrow;
    logic          subHalfNoBorrow;

    // Shared subtractor for both subtract forms.
    bao_subtractor #(
        .WIDTH        (DW)
    ) u_sub (
        .minuend      (subMinuend),
        .subtrahend   (accumulator),
        .difference   (subResult),
        .noBorrow     (subNoBorrow),
        .halfNoBorrow (subHalfNoBorrow)
    );

    // Rotate right: old carry enters the top bit, bit 0 leaves into carry.
    wire [DW-1:0] rotResult = {carryFlag, regReadData[DW-1:1]};

    // Nibble exchange of the register operand.
    wire [DW-1:0] swapResult = {regReadData[bao_pkg::NIBBLE_WIDTH-1:0],
                                regReadData[DW-1:bao_pkg::NIBBLE_WIDTH]};

    // Exclusive OR with literal or register.
    wire [DW-1:0] xorOperand = isLitXor ? literal : regReadData;
    wire [DW-1:0] xorResult  = accumulator ^ xorOperand;

    // Result selection.
    wire isSub = isLitSub || isRegSub;
    wire isXor = isLitXor || isRegXor;
    wire [DW-1:0] opResult = isSub    ? subResult  :
                             isRotate ? rotResult  :
                             isSwap   ? swapResult : xorResult;

    // Zero detection on the full eight bit result.
    wire resultZero = (opResult == {DW{1'b0}});

    //--------------------------------------------------------------------------
    // Destination steering.
    //--------------------------------------------------------------------------

    // Literal forms always target the accumulator.
    wire dataOp   = awake && (isSub || isRotate || isSwap || isXor);
    wire litForm  = isLitSub || isLitXor;
    wire toReg    = dataOp && !litForm && destIsReg;
    wire toAcc    = dataOp && !toReg;

    // Register file write port is a one-cycle strobe with registered data.
    wire [DW-1:0] next_regWriteData = toReg ? opResult : regWriteData;
    wire [AW-1:0] next_regWriteAddr = toReg ? regAddr : regWriteAddr;

    // Accumulator next value.
    wire [DW-1:0] next_accumulator = toAcc ? opResult : accumulator;

    //--------------------------------------------------------------------------
    // Status flag next values.
    //--------------------------------------------------------------------------

    // Carry: no borrow on subtract, shifted-out bit on rotate.
    wire next_carryFlag = !awake   ? carryFlag :
                          isSub    ? subNoBorrow :
                          isRotate ? regReadData[0] : carryFlag;

    // Half carry only on subtract.
    wire next_halfCarryFlag = (awake && isSub) ? subHalfNoBorrow
                                               : halfCarryFlag;

    // Zero flag on subtract and xor only; rotate and swap leave it.
    wire next_zeroFlag = (awake && (isSub || isXor)) ? resultZero
                                                     : zeroFlag;

    // Of the status flags, power-down touches only the two reset-status flags.
    wire enterSleep = awake && isPowerDown;
    wire next_expiryFlag = enterSleep ? bao_pkg::EXPIRY_ON_SLEEP
                                      : expiryFlag;
    wire next_sleepEnteredFlag = enterSleep ? bao_pkg::SLEEP_ON_SLEEP
                                            : sleepEnteredFlag;

    // Sleep holds until the wake request from the surrounding core.
    wire next_sleepMode = enterSleep ? 1'b1 : (wakeUp ? 1'b0 : sleepMode);

    //--------------------------------------------------------------------------
    // Data path registers.
    //--------------------------------------------------------------------------

    // Accumulator and write port registers.
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            accumulator  <= bao_pkg::ACC_RESET;
            regWriteEn   <= 1'b0;
            regWriteAddr <= {AW{1'b0}};
            regWriteData <= {DW{1'b0}};
        end
        else
        begin
            accumulator  <= next_accumulator;
            regWriteEn   <= toReg;
            regWriteAddr <= next_regWriteAddr;
            regWriteData <= next_regWriteData;
        end
    end

    // Status flag registers.
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            carryFlag        <= bao_pkg::CARRY_RESET;
            halfCarryFlag    <= bao_pkg::HALF_RESET;
            zeroFlag         <= bao_pkg::ZERO_RESET;
            expiryFlag       <= bao_pkg::EXPIRY_RESET;
            sleepEnteredFlag <= bao_pkg::SLEEP_RESET;
        end
        else
        begin
            carryFlag        <= next_carryFlag;
            halfCarryFlag    <= next_halfCarryFlag;
            zeroFlag         <= next_zeroFlag;
            expiryFlag       <= next_expiryFlag;
            sleepEnteredFlag <= next_sleepEnteredFlag;
        end
    end

    //--------------------------------------------------------------------------
    // Power-down control.
    //--------------------------------------------------------------------------

    // Clear strobes to the watchdog, and the sleep state. The watchdog itself
    // lives elsewhere; this block only commands the clear and the value.
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            watchdogClear  <= 1'b0;
            prescalerClear <= 1'b0;
            sleepMode      <= 1'b0;
        end
        else
        begin
            watchdogClear  <= enterSleep;
            prescalerClear <= enterSleep;
            sleepMode      <= next_sleepMode;
        end
    end

    // Clear values are constants; they are driven as ports for the watchdog.
    assign watchdogClearValue  = bao_pkg::WDOG_CLEAR_VALUE;
    assign prescalerClearValue = bao_pkg::PRESC_CLEAR_VALUE;

    // Oscillator runs whenever the core is not asleep.
    assign oscillatorRun = !sleepMode;

endmodule : bao_byte_alu

// ### hdl/bao_pkg.sv
//------------------------------------------------------------------------------
// Shared constants for the byte ALU operation subset.
//------------------------------------------------------------------------------
package bao_pkg;

    // Data path width and register file address width.
    localparam int DATA_WIDTH = 8;
    localparam int ADDR_WIDTH = 7;

    // Value loaded into the watchdog counter by the power-down operation.
    localparam logic [7:0] WDOG_CLEAR_VALUE = 8'h00;
    // Value loaded into the watchdog prescaler by the power-down operation.
    localparam logic [7:0] PRESC_CLEAR_VALUE = 8'h00;

    // Reset values of the status flags and the accumulator.
    localparam logic       EXPIRY_RESET   = 1'h1;
    localparam logic       SLEEP_RESET    = 1'h1;
    localparam logic       CARRY_RESET    = 1'h0;
    localparam logic       HALF_RESET     = 1'h0;
    localparam logic       ZERO_RESET     = 1'h0;
    localparam logic [7:0] ACC_RESET      = 8'h00;

    // Values written to the status flags by the power-down operation.
    localparam logic       EXPIRY_ON_SLEEP = 1'h1;
    localparam logic       SLEEP_ON_SLEEP  = 1'h0;

    // Nibble boundary used by the half carry and the nibble exchange.
    localparam int NIBBLE_WIDTH = 4;

    // Operation selector.
    typedef enum logic [2:0] {
        BAO_OP_NONE,
        BAO_OP_POWER_DOWN,
        BAO_OP_LITERAL_MINUS_ACC,
        BAO_OP_ROTATE_RIGHT_VIA_CARRY,
        BAO_OP_REG_MINUS_ACC,
        BAO_OP_NIBBLE_EXCHANGE,
        BAO_OP_LITERAL_XOR,
        BAO_OP_REG_XOR
    } bao_op_t;

endpackage : bao_pkg

// ### hdl/bao_subtractor.sv
`timescale 1ns/100ps
//------------------------------------------------------------------------------
// Eight bit subtractor: minuend minus subtrahend with no-borrow outputs.
//------------------------------------------------------------------------------
module bao_subtractor #(
    parameter int WIDTH = bao_pkg::DATA_WIDTH
) (
    input  wire logic [WIDTH-1:0] minuend,
    input  wire logic [WIDTH-1:0] subtrahend,
    output logic      [WIDTH-1:0] difference,
    output logic                  noBorrow,
    output logic                  halfNoBorrow
);

    // Two's complement: minuend plus inverted subtrahend plus one.
    // The carry out of that sum is high exactly when no borrow occurred.
    logic [WIDTH:0] fullSum;
    logic [bao_pkg::NIBBLE_WIDTH:0] lowSum;

    // Full width sum with the carry kept in the top bit.
    assign fullSum = {1'b0, minuend} + {1'b0, ~subtrahend} + {{WIDTH{1'b0}}, 1'b1};

    // Low nibble sum gives the carry out of bit 3 for the half carry flag.
    assign lowSum = {1'b0, minuend[bao_pkg::NIBBLE_WIDTH-1:0]}
                  + {1'b0, ~subtrahend[bao_pkg::NIBBLE_WIDTH-1:0]}
                  + {{bao_pkg::NIBBLE_WIDTH{1'b0}}, 1'b1};

    assign difference   = fullSum[WIDTH-1:0];
    assign noBorrow     = fullSum[WIDTH];
    assign halfNoBorrow = lowSum[bao_pkg::NIBBLE_WIDTH];

endmodule : bao_subtractor

// ### tb/bao_byte_alu_props.sv
`timescale 1ns/100ps
//------------------------------------------------------------------------------
// Port-level checker for the byte ALU subset.
//------------------------------------------------------------------------------
module bao_byte_alu_props #(
    parameter int DW = bao_pkg::DATA_WIDTH,
    parameter int AW = bao_pkg::ADDR_WIDTH
) (
    input wire logic             clock, reset, opValid, destIsReg, wakeUp, regWriteEn,
    input wire bao_pkg::bao_op_t opCode,
    input wire logic [DW-1:0]    literal, regReadData, regWriteData, accumulator,
    input wire logic [AW-1:0]    regAddr, regWriteAddr,
    input wire logic             carryFlag, zeroFlag, expiryFlag, sleepEnteredFlag,
    input wire logic             watchdogClear, prescalerClear, sleepMode, oscillatorRun,
    input wire logic [7:0]       watchdogClearValue, prescalerClearValue
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    // An operation only counts when the core is awake.
    wire taken = opValid && !sleepMode;
    wire pd    = taken && opCode == bao_pkg::BAO_OP_POWER_DOWN;

    AST_PD_CLEAR: assert property (pd |=> watchdogClear && prescalerClear
        && watchdogClearValue == 8'h00 && prescalerClearValue == 8'h00 ##1 !watchdogClear)
        else $error("power-down clear pulses wrong");
    AST_PD_FLAGS: assert property (pd |=> expiryFlag && !sleepEnteredFlag
        && $stable(carryFlag) && $stable(zeroFlag)) else $error("power-down flags wrong");
    AST_PD_SLEEP: assert property (pd |=> sleepMode && !oscillatorRun)
        else $error("power-down did not stop the oscillator");
    AST_ASLEEP: assert property (sleepMode && !wakeUp |=> sleepMode
        && $stable(accumulator) && !regWriteEn) else $error("activity while asleep");
    AST_SUBL: assert property (taken && opCode == bao_pkg::BAO_OP_LITERAL_MINUS_ACC |=>
        accumulator == $past(literal) - $past(accumulator)
        && carryFlag == ($past(literal) >= $past(accumulator))) else $error("literal subtract");
    AST_ROT: assert property (taken && opCode == bao_pkg::BAO_OP_ROTATE_RIGHT_VIA_CARRY
        && !destIsReg |=> accumulator == ({$past(carryFlag), 7'h00} | ($past(regReadData) >> 1))
        && carryFlag == $past(regReadData[0])) else $error("rotate result wrong");
    AST_SUBW: assert property (taken && opCode == bao_pkg::BAO_OP_REG_MINUS_ACC && destIsReg
        |=> regWriteEn && regWriteData == $past(regReadData) - $past(accumulator)
        && $stable(accumulator)) else $error("register subtract");
    AST_SWAP: assert property (taken && opCode == bao_pkg::BAO_OP_NIBBLE_EXCHANGE && destIsReg
        |=> regWriteEn && regWriteAddr == $past(regAddr) && $stable(zeroFlag)
        && regWriteData == (($past(regReadData) << 4) | ($past(regReadData) >> 4)))
        else $error("nibble exchange wrong");
    AST_XOR: assert property (taken && opCode == bao_pkg::BAO_OP_REG_XOR && !destIsReg |=>
        accumulator == ($past(accumulator) ^ $past(regReadData)) && !regWriteEn
        && zeroFlag == (accumulator == 8'h00)) else $error("register xor wrong");

    CV_PD: cover property (pd);
    CV_SWAP: cover property (taken && opCode == bao_pkg::BAO_OP_NIBBLE_EXCHANGE && destIsReg);
    CV_REFUSED: cover property (sleepMode && opValid);
endmodule : bao_byte_alu_props

bind bao_byte_alu bao_byte_alu_props #(.DW(DW), .AW(AW)) i_bao_byte_alu_props (
    .clock(clock), .reset(reset), .opValid(opValid), .destIsReg(destIsReg),
    .wakeUp(wakeUp), .regWriteEn(regWriteEn), .opCode(opCode), .literal(literal),
    .regReadData(regReadData), .regWriteData(regWriteData), .accumulator(accumulator),
    .regAddr(regAddr), .regWriteAddr(regWriteAddr), .carryFlag(carryFlag),
    .zeroFlag(zeroFlag), .expiryFlag(expiryFlag), .sleepEnteredFlag(sleepEnteredFlag),
    .watchdogClear(watchdogClear), .prescalerClear(prescalerClear), .sleepMode(sleepMode),
    .oscillatorRun(oscillatorRun), .watchdogClearValue(watchdogClearValue),
    .prescalerClearValue(prescalerClearValue));

// ### tb/bao_byte_alu_tb_top.sv
`timescale 1ns/100ps
//------------------------------------------------------------------------------
// Self-checking bench: driver queues expectations, monitor compares them.
//------------------------------------------------------------------------------
module bao_byte_alu_tb_top;
    typedef struct packed {
        logic [7:0] acc, wd;
        logic [6:0] wa;
        logic       c, dc, z, we, pd, sl, ex, sp;
    } bao_exp_t;
    bao_pkg::bao_op_t opCode = bao_pkg::BAO_OP_NONE;
    logic [7:0] literal = 8'h00, regReadData = 8'h00, mAcc = 8'h00;
    logic [7:0] regWriteData, accumulator, wdVal, psVal;
    logic [6:0] regAddr = 7'h00, regWriteAddr, regReadAddr;
    logic       clock, reset = 1'h1, opValid = 1'h0, destIsReg = 1'h0, wakeUp = 1'h0;
    logic       regWriteEn, carryFlag, halfCarryFlag, zeroFlag, expiryFlag, sleepEnteredFlag;
    logic       watchdogClear, prescalerClear, sleepMode, oscillatorRun, pend = 1'h0;
    // Reference model state, updated in the order operations are issued.
    logic       mC = 1'h0, mDc = 1'h0, mZ = 1'h0, mSleep = 1'h0, mExp = 1'h1, mSlp = 1'h1;
    int         nFail = 0, checkCount = 0, cycles = 0;
    bao_exp_t   expQ[$];

    bao_byte_alu i_bao_byte_alu (.clock(clock), .reset(reset), .opValid(opValid),
        .opCode(opCode), .literal(literal), .regAddr(regAddr), .destIsReg(destIsReg),
        .regReadData(regReadData), .wakeUp(wakeUp), .regReadAddr(regReadAddr),
        .regWriteEn(regWriteEn),
        .regWriteAddr(regWriteAddr), .regWriteData(regWriteData), .accumulator(accumulator),
        .carryFlag(carryFlag), .halfCarryFlag(halfCarryFlag), .zeroFlag(zeroFlag),
        .expiryFlag(expiryFlag), .sleepEnteredFlag(sleepEnteredFlag),
        .watchdogClear(watchdogClear), .prescalerClear(prescalerClear),
        .watchdogClearValue(wdVal), .prescalerClearValue(psVal), .sleepMode(sleepMode),
        .oscillatorRun(oscillatorRun));

    initial
    begin
        clock = 1'h0;
        forever #25 clock = ~clock;
    end

    task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
        checkCount++;
        if (got !== exp)
        begin
            nFail++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic report_and_stop();
        if (nFail == 0 && checkCount > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : report_and_stop

    // Models one operation, queues its expected outcome, then issues it back to back.
    task automatic doOp(bao_pkg::bao_op_t op, logic [7:0] lit, logic [6:0] adr, logic d,
                        logic [7:0] rd);
        bao_exp_t   e;
        logic [7:0] a;
        logic [7:0] r;
        logic       lf;
        lf = (op == bao_pkg::BAO_OP_LITERAL_MINUS_ACC || op == bao_pkg::BAO_OP_LITERAL_XOR);
        a = lf ? lit : rd;
        e = '0;
        r = mAcc;
        if (!mSleep)
        begin
            case (op)
                bao_pkg::BAO_OP_POWER_DOWN:
                begin
                    e.pd = 1'h1;
                    mSleep = 1'h1;
                    mExp = 1'h1;
                    mSlp = 1'h0;
                end
                bao_pkg::BAO_OP_LITERAL_MINUS_ACC, bao_pkg::BAO_OP_REG_MINUS_ACC:
                begin
                    r = a - mAcc;
                    mC = (a >= mAcc);
                    mDc = (a[3:0] >= mAcc[3:0]);
                    mZ = (r == 8'h00);
                end
                bao_pkg::BAO_OP_ROTATE_RIGHT_VIA_CARRY:
                begin
                    r = {mC, a[7:1]};
                    mC = a[0];
                end
                bao_pkg::BAO_OP_NIBBLE_EXCHANGE: r = {a[3:0], a[7:4]};
                bao_pkg::BAO_OP_LITERAL_XOR, bao_pkg::BAO_OP_REG_XOR:
                begin
                    r = a ^ mAcc;
                    mZ = (r == 8'h00);
                end
                default: ;
            endcase
            // Literal forms always land in the accumulator whatever the destination bit.
            e.we = d && !lf && op > bao_pkg::BAO_OP_POWER_DOWN;
            if (e.we)
                e.wd = r;
            else if (op > bao_pkg::BAO_OP_POWER_DOWN)
                mAcc = r;
        end
        e.acc = mAcc;
        e.wa = adr;
        {e.c, e.dc, e.z, e.sl, e.ex, e.sp} = {mC, mDc, mZ, mSleep, mExp, mSlp};
        expQ.push_back(e);
        @(posedge clock);
        opValid <= 1'h1;
        opCode <= op;
        literal <= lit;
        regAddr <= adr;
        destIsReg <= d;
        regReadData <= rd;
    endtask : doOp

    // A result shows one edge after the edge that sampled the operation.
    always @(posedge clock)
    begin : monitor
        bao_exp_t e;
        if (pend)
        begin
            e = expQ.pop_front();
            chk("accumulator", e.acc, accumulator);
            chk("carryFlag", {7'h00, e.c}, {7'h00, carryFlag});
            chk("halfCarryFlag", {7'h00, e.dc}, {7'h00, halfCarryFlag});
            chk("zeroFlag", {7'h00, e.z}, {7'h00, zeroFlag});
            chk("regWriteEn", {7'h00, e.we}, {7'h00, regWriteEn});
            if (e.we)
            begin
                chk("regWriteData", e.wd, regWriteData);
                chk("regWriteAddr", {1'h0, e.wa}, {1'h0, regWriteAddr});
            end
            chk("expiryFlag", {7'h00, e.ex}, {7'h00, expiryFlag});
            chk("sleepEnteredFlag", {7'h00, e.sp}, {7'h00, sleepEnteredFlag});
            chk("watchdogClear", {7'h00, e.pd}, {7'h00, watchdogClear});
            chk("prescalerClear", {7'h00, e.pd}, {7'h00, prescalerClear});
            // The clear values are fixed at zero whatever the operation.
            chk("watchdogClearValue", 8'h00, wdVal);
            chk("prescalerClearValue", 8'h00, psVal);
            // The register operand address follows the address being driven now.
            chk("regReadAddr", {1'h0, regAddr}, {1'h0, regReadAddr});
            chk("oscillatorRun", {7'h00, !e.sl}, {7'h00, oscillatorRun});
        end
        pend = opValid && !reset;
    end

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            nFail++;
            report_and_stop();
        end
    end

    initial
    begin
        void'($urandom(52453));
        repeat (20) @(posedge clock);
        reset <= 1'h0;
        repeat (300) doOp(bao_pkg::bao_op_t'(3'(2 + $urandom_range(5))), 8'($urandom),
            7'($urandom), 1'($urandom), ($urandom_range(2) == 0) ? 8'hFF : 8'($urandom));
        doOp(bao_pkg::BAO_OP_LITERAL_MINUS_ACC, mAcc, 7'h7F, 1'h1, 8'h00);
        doOp(bao_pkg::BAO_OP_LITERAL_XOR, mAcc, 7'h00, 1'h1, 8'h00);
        doOp(bao_pkg::BAO_OP_POWER_DOWN, 8'h00, 7'h00, 1'h0, 8'h00);
        doOp(bao_pkg::BAO_OP_REG_XOR, 8'h5A, 7'h01, 1'h1, 8'h3C);
        @(posedge clock);
        opValid <= 1'h0;
        wakeUp <= 1'h1;
        @(posedge clock);
        wakeUp <= 1'h0;
        mSleep = 1'h0;
        doOp(bao_pkg::BAO_OP_NONE, 8'hFF, 7'h7F, 1'h1, 8'hFF);
        doOp(bao_pkg::BAO_OP_NIBBLE_EXCHANGE, 8'h00, 7'h7F, 1'h1, 8'hA5);
        doOp(bao_pkg::BAO_OP_REG_MINUS_ACC, 8'h00, 7'h40, 1'h1, 8'h00);
        @(posedge clock);
        opValid <= 1'h0;
        repeat (3) @(posedge clock);
        report_and_stop();
    end
endmodule : bao_byte_alu_tb_top
